// File: design/node_processor_register_port.sv
// Node processor register port: strobe/ready slave, register decode, attention lines.
// Assumes all pins are synchronous to clk_sys, which stands in for the byte clock,
// and that the core supplies status flags, a buffer transfer busy level and takes commands.
// Notes on behaviour
// - Strapped select high gives synchronous timing; low gives strobe/ready handshake.
// - Asynchronous mode drives data only with select and strobe low, read high.
// - Synchronous mode drives data with select low and read high, any strobe.
// - Synchronous mode latches register select with the strobe on a clock edge.
// - Read line high reads from the device; low writes into it.
// - Register select decodes either a register address or a command code.
// - Sixteen-bit data bus is released whenever no read data are driven.
// - Asynchronous ready asserts after read data placed or write data taken.
// - Asynchronous ready releases once select or strobe returns high.
// - Synchronous ready asserts one edge after the strobe edge, releases at the next edge.
// - Synchronous buffer window access waits for pending buffer transfer to finish.
// - First attention line asserts for any unmasked flag of status one.
// - First attention drops on either half read; re-arms after both halves read.
// - Second attention line asserts for any unmasked flag of status two.
// - Second attention drops on either half read; re-arms after both halves read.
module node_processor_register_port #(
  parameter int unsigned DATA_W = np_port_pkg::DATA_W,
  parameter int unsigned ADDR_W = np_port_pkg::ADDR_W
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              port_timing_select,
  input  wire logic              chip_select_n,
  input  wire logic              transfer_strobe_n,
  input  wire logic              read_not_write,
  input  wire logic [ADDR_W-1:0] register_select_bus,
  input  wire logic [DATA_W-1:0] host_data_bus_in,
  output logic      [DATA_W-1:0] host_data_bus_out,
  output logic                   host_data_bus_oe,
  output logic                   ready_n_out,
  output logic                   ready_n_oe,
  output logic                   tx_attention_irq_n_out,
  output logic                   tx_attention_irq_n_oe,
  output logic                   rx_attention_irq_n_out,
  output logic                   rx_attention_irq_n_oe,
  input  wire logic [31:0]       status_one_flags,
  input  wire logic [31:0]       status_two_flags,
  input  wire logic              buffer_busy,
  input  wire logic [DATA_W-1:0] buffer_window_rd_data,
  output logic                   buffer_window_wr,
  output logic                   buffer_window_rd,
  output logic      [DATA_W-1:0] buffer_window_wr_data,
  output logic                   command_valid,
  output logic      [ADDR_W-1:0] command_code
);

  np_port_pkg::port_state_e state_reg, state_next;
  np_port_pkg::port_access_s acc_reg;
  logic              sync_mode_reg;
  logic [DATA_W-1:0] rd_word_reg;
  logic [15:0]       mask1_lo_reg, mask1_hi_reg, mask2_lo_reg, mask2_hi_reg;
  logic              ready_reg;
  logic              prev_rst_reg;
  logic [DATA_W-1:0] gen_rd_data;

  // Strap is caught by a clocked process after reset release, never under the reset itself.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prev_rst_reg  <= 1'b1;
      sync_mode_reg <= 1'b0;
    end
    else
    begin
      prev_rst_reg <= 1'b0;
      if (prev_rst_reg)
      begin
        sync_mode_reg <= port_timing_select;
      end
    end
  end

  // Start of an access needs select and strobe low together.
  wire start_access = !chip_select_n && !transfer_strobe_n;
  wire released     = chip_select_n || transfer_strobe_n;
  wire is_command   = (acc_reg.sel >= np_port_pkg::SEL_COMMAND_BASE);
  wire is_window    = (acc_reg.sel == np_port_pkg::SEL_BUFFER_WINDOW);
  wire is_general   = (acc_reg.sel >= 7'h10) && !is_command;
  // Only the buffer window waits on a busy buffer; other registers answer at once.
  wire commit       = (state_reg == np_port_pkg::ST_WAIT) && !(buffer_busy && is_window);

  // Handshake state: idle, waiting on the buffer, done for one cycle (synchronous) or until the strobe lets go.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      np_port_pkg::ST_IDLE:
        if (start_access)
        begin
          state_next = np_port_pkg::ST_WAIT;
        end
      np_port_pkg::ST_WAIT:
        if (commit)
        begin
          state_next = np_port_pkg::ST_DONE;
        end
      np_port_pkg::ST_DONE:
        // Synchronous ready is one cycle; asynchronous holds until release.
        if (sync_mode_reg || released)
        begin
          state_next = np_port_pkg::ST_IDLE;
        end
      default:
        state_next = np_port_pkg::ST_IDLE;
    endcase
  end

  // Access latch: select and direction taken at the start edge; write data follow the bus until done.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= np_port_pkg::ST_IDLE;
      acc_reg   <= '0;
      ready_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ready_reg <= commit;
      if (state_reg == np_port_pkg::ST_IDLE && start_access)
      begin
        acc_reg.sel   <= register_select_bus;
        acc_reg.write <= !read_not_write;
      end
      if (state_reg != np_port_pkg::ST_DONE && !read_not_write)
      begin
        acc_reg.data <= host_data_bus_in;
      end
    end
  end

  wire wr_commit = commit && acc_reg.write && !is_command;
  wire rd_commit = commit && !acc_reg.write && !is_command;

  // Read multiplexer for status, masks and the buffer window.
  logic [DATA_W-1:0] rd_mux;
  always_comb
  begin
    case (acc_reg.sel)
      np_port_pkg::SEL_STATUS_ONE_LOW:  rd_mux = status_one_flags[15:0];
      np_port_pkg::SEL_STATUS_ONE_HIGH: rd_mux = status_one_flags[31:16];
      np_port_pkg::SEL_STATUS_TWO_LOW:  rd_mux = status_two_flags[15:0];
      np_port_pkg::SEL_STATUS_TWO_HIGH: rd_mux = status_two_flags[31:16];
      np_port_pkg::SEL_BUFFER_WINDOW:   rd_mux = buffer_window_rd_data;
      np_port_pkg::SEL_MASK_ONE_LOW:    rd_mux = mask1_lo_reg;
      np_port_pkg::SEL_MASK_ONE_HIGH:   rd_mux = mask1_hi_reg;
      np_port_pkg::SEL_MASK_TWO_LOW:    rd_mux = mask2_lo_reg;
      np_port_pkg::SEL_MASK_TWO_HIGH:   rd_mux = mask2_hi_reg;
      default:                          rd_mux = is_general ? gen_rd_data : '0;
    endcase
  end

  // Mask registers and the read word; half reads feed the attention re-arm.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mask1_lo_reg <= np_port_pkg::MASK_RESET;
      mask1_hi_reg <= np_port_pkg::MASK_RESET;
      mask2_lo_reg <= np_port_pkg::MASK_RESET;
      mask2_hi_reg <= np_port_pkg::MASK_RESET;
      rd_word_reg  <= '0;
    end
    else
    begin
      if (rd_commit)
      begin
        rd_word_reg <= rd_mux;
      end
      if (wr_commit && acc_reg.sel == np_port_pkg::SEL_MASK_ONE_LOW)
      begin
        mask1_lo_reg <= acc_reg.data;
      end
      if (wr_commit && acc_reg.sel == np_port_pkg::SEL_MASK_ONE_HIGH)
      begin
        mask1_hi_reg <= acc_reg.data;
      end
      if (wr_commit && acc_reg.sel == np_port_pkg::SEL_MASK_TWO_LOW)
      begin
        mask2_lo_reg <= acc_reg.data;
      end
      if (wr_commit && acc_reg.sel == np_port_pkg::SEL_MASK_TWO_HIGH)
      begin
        mask2_hi_reg <= acc_reg.data;
      end
    end
  end

  // Half-read strobes and pending levels; bit 0 is status one, bit 1 is status two.
  wire rd1_lo = rd_commit && acc_reg.sel == np_port_pkg::SEL_STATUS_ONE_LOW;
  wire rd1_hi = rd_commit && acc_reg.sel == np_port_pkg::SEL_STATUS_ONE_HIGH;
  wire rd2_lo = rd_commit && acc_reg.sel == np_port_pkg::SEL_STATUS_TWO_LOW;
  wire rd2_hi = rd_commit && acc_reg.sel == np_port_pkg::SEL_STATUS_TWO_HIGH;
  wire pend1  = |(status_one_flags & {mask1_hi_reg, mask1_lo_reg});
  wire pend2  = |(status_two_flags & {mask2_hi_reg, mask2_lo_reg});
  wire [1:0] half_lo = {rd2_lo, rd1_lo};
  wire [1:0] half_hi = {rd2_hi, rd1_hi};
  wire [1:0] pend    = {pend2, pend1};
  wire [1:0] irq_line;

  // Attention lines: a half read drops the line and disarms it until both halves are read.
  // Disarming keeps a still-set flag from re-raising the line between the two half reads.
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_attention
    logic       irq_reg;
    logic       armed_reg;
    logic [1:0] read_reg;
    wire        half_rd   = half_lo[ch] || half_hi[ch];
    wire  [1:0] read_next = read_reg | {half_hi[ch], half_lo[ch]};
    assign irq_line[ch] = irq_reg;
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        irq_reg   <= 1'b0;
        armed_reg <= 1'b1;
        read_reg  <= np_port_pkg::HALVES_NONE;
      end
      else
      begin
        // A half read wins over a flag setting in the same cycle; the line must drop.
        irq_reg <= !half_rd && (irq_reg || (armed_reg && pend[ch]));
        if (irq_reg && half_rd)
        begin
          armed_reg <= 1'b0;
          read_reg  <= {half_hi[ch], half_lo[ch]};
        end
        else if (!armed_reg && read_next == np_port_pkg::HALVES_BOTH)
        begin
          armed_reg <= 1'b1;
          read_reg  <= np_port_pkg::HALVES_NONE;
        end
        else
        begin
          read_reg <= read_next;
        end
      end
    end
  end

  // General registers live in the small memory. The address follows the select pins
  // while idle, so the read word of a newly selected register is ready in the commit cycle.
  wire [3:0] gen_addr = (state_reg == np_port_pkg::ST_IDLE) ? register_select_bus[3:0]
                                                            : acc_reg.sel[3:0];
  np_reg_mem #(
    .DEPTH (np_port_pkg::GEN_DEPTH),
    .WIDTH (DATA_W)
  ) np_reg_mem_i (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .wr_en   (wr_commit && is_general),
    .addr    (gen_addr),
    .wr_data (acc_reg.data),
    .rd_data (gen_rd_data)
  );

  // Pin drive: open-drain lines only ever pull low.
  wire drive_async = !sync_mode_reg && !chip_select_n && !transfer_strobe_n
                     && read_not_write;
  wire drive_sync  = sync_mode_reg && !chip_select_n && read_not_write;
  assign host_data_bus_oe       = drive_async || drive_sync;
  assign host_data_bus_out      = rd_word_reg;
  assign ready_n_out            = 1'b0;
  assign ready_n_oe             = ready_reg || (!sync_mode_reg && state_reg ==
                                  np_port_pkg::ST_DONE && !released);
  assign tx_attention_irq_n_out = 1'b0;
  assign tx_attention_irq_n_oe  = irq_line[0];
  assign rx_attention_irq_n_out = 1'b0;
  assign rx_attention_irq_n_oe  = irq_line[1];

  // Core side strobes.
  assign buffer_window_wr      = wr_commit && acc_reg.sel == np_port_pkg::SEL_BUFFER_WINDOW;
  assign buffer_window_rd      = rd_commit && acc_reg.sel == np_port_pkg::SEL_BUFFER_WINDOW;
  assign buffer_window_wr_data = acc_reg.data;
  assign command_valid         = commit && is_command;
  assign command_code          = acc_reg.sel;

endmodule // node_processor_register_port

// File: design/np_port_pkg.sv
// Package for the node processor register port: widths, select codes and carrier struct.
// Assumes a single 125 MHz system clock that stands in for the byte clock.
package np_port_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;

  // Register select codes seen by the port (internal map of the device core).
  localparam logic [6:0] SEL_STATUS_ONE_LOW  = 7'h00;
  localparam logic [6:0] SEL_STATUS_ONE_HIGH = 7'h01;
  localparam logic [6:0] SEL_STATUS_TWO_LOW  = 7'h02;
  localparam logic [6:0] SEL_STATUS_TWO_HIGH = 7'h03;
  localparam logic [6:0] SEL_BUFFER_WINDOW   = 7'h04;
  localparam logic [6:0] SEL_MASK_ONE_LOW    = 7'h08;
  localparam logic [6:0] SEL_MASK_ONE_HIGH   = 7'h09;
  localparam logic [6:0] SEL_MASK_TWO_LOW    = 7'h0a;
  localparam logic [6:0] SEL_MASK_TWO_HIGH   = 7'h0b;
  // Select codes at or above this value are commands, not register addresses.
  localparam logic [6:0] SEL_COMMAND_BASE    = 7'h40;

  // Number of plain general registers kept in the small register memory.
  localparam int unsigned GEN_DEPTH  = 16;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [1:0]  HALVES_NONE = 2'h0;
  localparam logic [1:0]  HALVES_BOTH = 2'h3;

  // One register access as issued toward the core.
  typedef struct packed {
    logic        write;
    logic [6:0]  sel;
    logic [15:0] data;
  } port_access_s;

  // Handshake states of the port.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } port_state_e;

endpackage : np_port_pkg

// File: design/np_reg_mem.sv
// Small register memory behind the node processor port; read data come out of a register.
// Assumes one synchronous clock and asynchronous active-high reset.
module np_reg_mem #(
  parameter int unsigned DEPTH = np_port_pkg::GEN_DEPTH,
  parameter int unsigned WIDTH = np_port_pkg::DATA_W
) (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Writes land at the edge; the read word is registered so it is stable for a cycle.
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem_reg[addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= mem_reg[addr];
    end
  end

endmodule // np_reg_mem

// File: verif/np_port_chk.sv
// Checker for the node processor register port, bound to its top module.
// Assumes the timing strap is held steady across each reset.
module np_port_chk (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        port_timing_select,
  input wire logic        chip_select_n,
  input wire logic        transfer_strobe_n,
  input wire logic        read_not_write,
  input wire logic [6:0]  register_select_bus,
  input wire logic [15:0] host_data_bus_in,
  input wire logic        host_data_bus_oe,
  input wire logic        ready_n_oe,
  input wire logic        tx_attention_irq_n_oe,
  input wire logic        rx_attention_irq_n_oe,
  input wire logic [31:0] status_one_flags,
  input wire logic [31:0] status_two_flags,
  input wire logic        buffer_busy,
  input wire logic        buffer_window_wr,
  input wire logic        buffer_window_rd,
  input wire logic [15:0] buffer_window_wr_data,
  input wire logic        command_valid,
  input wire logic [6:0]  command_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Select decode used by several properties below.
  wire sync_mode = port_timing_select;
  wire st_one    = register_select_bus[6:1] == 6'h00;
  wire st_two    = register_select_bus[6:1] == 6'h01;
  wire win       = register_select_bus == np_port_pkg::SEL_BUFFER_WINDOW;
  wire both_low  = !chip_select_n && !transfer_strobe_n;

  property p_async_oe;
    !sync_mode |-> host_data_bus_oe == (both_low && read_not_write);
  endproperty
  a_async_oe: assert property (p_async_oe) else $error("async data drive wrong");
  property p_sync_oe;
    sync_mode |-> host_data_bus_oe == (!chip_select_n && read_not_write);
  endproperty
  a_sync_oe: assert property (p_sync_oe) else $error("sync data drive wrong");
  property p_sync_pulse;
    sync_mode && ready_n_oe |=> !ready_n_oe;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync ready too long");
  // Asynchronous ready that stood last cycle must still stand while select and strobe stay low.
  property p_async_hold;
    !sync_mode && $past(ready_n_oe) && both_low |-> ready_n_oe;
  endproperty
  a_async_hold: assert property (p_async_hold) else $error("async ready dropped");
  property p_async_drop;
    !sync_mode && ready_n_oe && !both_low |-> ##[1:2] !ready_n_oe;
  endproperty
  a_async_drop: assert property (p_async_drop) else $error("async ready stuck");
  property p_ready_cause;
    $rose(ready_n_oe) |-> $past(chip_select_n) == 1'b0 && $past(transfer_strobe_n) == 1'b0;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without request");
  property p_window_wait;
    $rose(ready_n_oe) && win |-> $past(buffer_busy) == 1'b0;
  endproperty
  a_window_wait: assert property (p_window_wait) else $error("ready while buffer busy");
  property p_cmd;
    command_valid |-> command_code == register_select_bus
      && register_select_bus >= np_port_pkg::SEL_COMMAND_BASE ##1 !command_valid;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command pulse wrong");
  property p_wr_capture;
    buffer_window_wr |-> buffer_window_wr_data == host_data_bus_in && !read_not_write;
  endproperty
  a_wr_capture: assert property (p_wr_capture) else $error("write data wrong");
  property p_window_rd;
    buffer_window_rd |-> win && read_not_write && both_low ##1 !buffer_window_rd;
  endproperty
  a_window_rd: assert property (p_window_rd) else $error("window read strobe wrong");
  property p_tx_drop;
    $rose(ready_n_oe) && read_not_write && st_one |-> !tx_attention_irq_n_oe;
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("first line not dropped");
  property p_rx_drop;
    $rose(ready_n_oe) && read_not_write && st_two |-> !rx_attention_irq_n_oe;
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("second line not dropped");
  property p_tx_cause;
    $rose(tx_attention_irq_n_oe) |-> $past(status_one_flags) != 32'h0;
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("first line without flag");
  property p_rx_cause;
    $rose(rx_attention_irq_n_oe) |-> $past(status_two_flags) != 32'h0;
  endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("second line without flag");
  // Main scenarios that the bench is expected to reach.
  c_sync: cover property (sync_mode && ready_n_oe);
  c_window: cover property ($rose(ready_n_oe) && win);
  c_async: cover property (!sync_mode && ready_n_oe ##1 ready_n_oe);
endmodule // np_port_chk

bind node_processor_register_port np_port_chk np_port_chk_i (.clk_sys, .sys_rst,
  .port_timing_select, .chip_select_n, .transfer_strobe_n, .read_not_write,
  .register_select_bus, .host_data_bus_in, .host_data_bus_oe, .ready_n_oe,
  .tx_attention_irq_n_oe, .rx_attention_irq_n_oe, .status_one_flags, .status_two_flags,
  .buffer_busy, .buffer_window_wr, .buffer_window_rd, .buffer_window_wr_data, .command_valid,
  .command_code);

// File: verif/host_cpu_model.sv
// Node processor model: issues one register access at a time on the port.
// Assumes the bench resolves the shared data bus from both drive enables.
module host_cpu_model (
  input  wire logic        clk_sys,
  input  wire logic        ready_n_oe,
  input  wire logic [15:0] bus_level,
  output logic             chip_select_n,
  output logic             transfer_strobe_n,
  output logic             read_not_write,
  output logic [6:0]       register_select_bus,
  output logic [15:0]      drive_data,
  output logic             drive_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero: nothing selected, nothing driven.
  initial
  begin
    chip_select_n = 1'b1;
    transfer_strobe_n = 1'b1;
    read_not_write = 1'b1;
    register_select_bus = 7'h00;
    drive_data = 16'h0000;
    drive_en = 1'b0;
  end
  // Everything is held until ready is sampled or 200 cycles pass, so an answer within 200 cycles never loses data.
  task automatic access(input logic wr, input logic [6:0] sel, input logic [15:0] d,
                        input int hold, output logic [15:0] q, output int waited);
    waited = 0;
    @(posedge clk_sys);
    chip_select_n <= 1'b0;
    transfer_strobe_n <= 1'b0;
    read_not_write <= !wr;
    register_select_bus <= sel;
    drive_data <= d;
    drive_en <= wr;
    do
    begin
      @(posedge clk_sys);
      waited++;
    end
    while (ready_n_oe !== 1'b1 && waited < 200);
    q = bus_level;
    repeat (hold) @(posedge clk_sys);
    chip_select_n <= 1'b1;
    transfer_strobe_n <= 1'b1;
    drive_en <= 1'b0;
  endtask
endmodule // host_cpu_model

// File: verif/node_processor_register_port_bench.sv
// Self-checking bench for the node processor register port.
// Assumes the checker is bound to the port by its own file.
module node_processor_register_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, sys_rst, port_timing_select, buffer_busy;
  logic [31:0] status_one_flags, status_two_flags;
  logic [15:0] rd_word, q;
  wire  [15:0] drive_data, host_data_bus_out, bus_level;
  wire  [6:0]  register_select_bus, command_code;
  wire         chip_select_n, transfer_strobe_n, read_not_write, drive_en, ready_n_oe;
  wire         host_data_bus_oe, tx_oe, rx_oe, command_valid;
  int          n_errors, check_count, waited, cmd_seen;
  logic [6:0]  cmd_last;

  // A released bus shows the inverse of the model's last drive_data so stale data never matches.
  assign bus_level = drive_en ? drive_data : (host_data_bus_oe ? host_data_bus_out : ~drive_data);

  node_processor_register_port node_processor_register_port_i (.clk_sys, .sys_rst,
    .port_timing_select, .chip_select_n, .transfer_strobe_n, .read_not_write,
    .register_select_bus, .host_data_bus_in(bus_level), .host_data_bus_out,
    .host_data_bus_oe, .ready_n_out(), .ready_n_oe, .tx_attention_irq_n_out(),
    .tx_attention_irq_n_oe(tx_oe), .rx_attention_irq_n_out(), .rx_attention_irq_n_oe(rx_oe),
    .status_one_flags, .status_two_flags, .buffer_busy, .buffer_window_rd_data(rd_word),
    .buffer_window_wr(), .buffer_window_rd(), .buffer_window_wr_data(), .command_valid,
    .command_code);
  host_cpu_model host_cpu_model_i (.clk_sys, .ready_n_oe, .bus_level, .chip_select_n,
    .transfer_strobe_n, .read_not_write, .register_select_bus, .drive_data, .drive_en);

  // Clock at 125 MHz.
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Command pulses are counted as they come, since they stand one cycle only.
  always @(posedge clk_sys)
    if (command_valid === 1'b1)
    begin
      cmd_seen++;
      cmd_last = command_code;
    end

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // One access; a hang counts as a mismatch and ends the run.
  task automatic xfer(input logic wr, input logic [6:0] sel, input logic [15:0] d, input int h);
    host_cpu_model_i.access(wr, sel, d, h, q, waited);
    check(waited < 200, "no ready");
    if (waited >= 200)
      complete_run();
  endtask
  task automatic reset_dut(input logic mode);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    port_timing_select <= mode;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  // Register writes read back, at both ends of the general range.
  // Both writes land before either read, so each read selects a register other than the last.
  task automatic rw_case(input int h);
    xfer(1'b1, 7'h10, 16'h3c5a, h);
    xfer(1'b1, 7'h3f, 16'h3c5b, h);
    xfer(1'b0, 7'h10, 16'h0000, h);
    check(q === 16'h3c5a, "read back low end");
    xfer(1'b0, 7'h3f, 16'h0000, h);
    check(q === 16'h3c5b, "read back high end");
  endtask
  task automatic cmd_case;
    cmd_seen = 0;
    xfer(1'b1, 7'h40, 16'h0000, 0);
    xfer(1'b1, 7'h7f, 16'h0000, 0);
    check(cmd_seen == 2 && cmd_last === 7'h7f, "command pulses");
  endtask
  task automatic window_case;
    buffer_busy <= 1'b1;
    fork
      xfer(1'b0, np_port_pkg::SEL_BUFFER_WINDOW, 16'h0000, 0);
      begin
        repeat (12) @(posedge clk_sys);
        buffer_busy <= 1'b0;
      end
    join
    check(waited > 12 && q === rd_word, "window wait");
    xfer(1'b1, np_port_pkg::SEL_BUFFER_WINDOW, 16'h1234, 0);
  endtask
  // Raise, drop on one half read, re-arm after both halves read.
  task automatic irq_case(input logic two);
    logic [6:0] base;
    base = two ? np_port_pkg::SEL_STATUS_TWO_LOW : np_port_pkg::SEL_STATUS_ONE_LOW;
    xfer(1'b1, base + 7'h08, 16'h0001, 0);
    if (two) status_two_flags <= 32'h1; else status_one_flags <= 32'h1;
    repeat (4) @(posedge clk_sys);
    check((two ? rx_oe : tx_oe) === 1'b1, "line not raised");
    xfer(1'b0, base, 16'h0000, 0);
    check(q === 16'h0001, "status low half");
    repeat (4) @(posedge clk_sys);
    check((two ? rx_oe : tx_oe) === 1'b0, "line re-armed early");
    xfer(1'b0, base + 7'h01, 16'h0000, 0);
    repeat (4) @(posedge clk_sys);
    check((two ? rx_oe : tx_oe) === 1'b1, "line not re-armed");
    status_one_flags <= 32'h0;
    status_two_flags <= 32'h0;
    xfer(1'b0, base, 16'h0000, 0);
    xfer(1'b0, base + 7'h01, 16'h0000, 0);
  endtask
  // Asynchronous ready stays while the strobe is held, then lets go.
  task automatic async_case;
    // The hold is judged mid-cycle while the strobe is still low, not at its release edge.
    fork
      xfer(1'b1, 7'h12, 16'ha55a, 3);
      begin
        repeat (5) @(posedge clk_sys);
        #1 check(ready_n_oe === 1'b1, "ready released early");
      end
    join
    repeat (3) @(posedge clk_sys);
    check(ready_n_oe === 1'b0, "ready stuck");
    xfer(1'b0, 7'h12, 16'h0000, 1);
    check(q === 16'ha55a, "async read");
  endtask

  // Main sequence: synchronous timing first, then the strobe handshake.
  initial
  begin
    sys_rst = 1'b1;
    port_timing_select = 1'b1;
    buffer_busy = 1'b0;
    status_one_flags = 32'h0;
    status_two_flags = 32'h0;
    rd_word = 16'hbe3d;
    reset_dut(1'b1);
    rw_case(0);
    cmd_case();
    window_case();
    irq_case(1'b0);
    irq_case(1'b1);
    reset_dut(1'b0);
    async_case();
    rw_case(1);
    complete_run();
  end
endmodule // node_processor_register_port_bench
